// File: hw/spi_flags_pkg.sv
/*
  Register map, field layouts, reset values and divisor table of the serial
  status, flag and data-register block.
  Assumes a 32-bit classic Wishbone bus with byte addresses, data in lane 0.
*/
package spi_flags_pkg;

  // Byte offsets of the three registers
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;

  // Width of the register offset field
  localparam int unsigned OFS_W = 4;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic rx_full_irq_enable;
    logic reserved6;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic wired_or;
    logic tx_empty_irq_enable;
    logic spi_enable;
  } ctrl_s;

  // Writable part of the status/control register
  typedef struct packed {
    logic       error_irq_enable;
    logic       mode_fault_enable;
    logic [1:0] rate_select;
  } stat_cfg_s;

  // Hardware flags of the status/control register
  typedef struct packed {
    logic rx_full_flag;
    logic overflow_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
  } flags_s;

  // Status/control bit positions
  localparam int unsigned RX_FULL_POS    = 7;
  localparam int unsigned ERR_IE_POS     = 6;
  localparam int unsigned OVERFLOW_POS   = 5;
  localparam int unsigned MODE_FAULT_POS = 4;
  localparam int unsigned TX_EMPTY_POS   = 3;
  localparam int unsigned MF_ENABLE_POS  = 2;
  localparam int unsigned RATE_HI_POS    = 1;
  localparam int unsigned RATE_LO_POS    = 0;

  // Reset values: master and phase set in control, transmit empty set
  localparam logic [7:0] CTRL_RST     = 8'h28;
  localparam logic [3:0] STAT_CFG_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST    = 4'h1;
  localparam logic [7:0] DATA_RST     = 8'h00;

  // Master baud divisors per rate select code
  localparam logic [7:0] BAUD_DIV_00 = 8'h02;
  localparam logic [7:0] BAUD_DIV_01 = 8'h08;
  localparam logic [7:0] BAUD_DIV_10 = 8'h20;
  localparam logic [7:0] BAUD_DIV_11 = 8'h80;

  // One serial clock period takes this many half-period ticks
  localparam int unsigned SCK_HALVES = 2;

  // System clock rate
  localparam int unsigned CLK_HZ = 10_000_000;

endpackage : spi_flags_pkg

// File: hw/spi_status_flags_and_data.sv
/*
  Status flags, interrupt gating, baud divider, slave-select ownership and
  split transmit/receive data register of a byte-wide serial interface,
  reached over a classic Wishbone slave port.
  Assumes a separate shift engine that takes the transmit byte, delivers
  completed receive bytes as one-cycle pulses and reports a byte in flight.
  Assumes the engine raises its take pulse only while a byte is pending,
  and holds its in-flight level from the first bit to the byte's end.
  Assumes the bus master waits for ack, which comes one cycle after the
  request is seen, and leaves one idle cycle between accesses.
  Assumes the slave-select pin is already synchronised; a metastable
  level would show as a false rising edge.
  All inputs are synchronous to clk_sys_i.
*/
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
// Function
// - Transmit-empty interrupt gated by its enable
// - Receive interrupt enable bit, reset clears
// - Received byte sets receive-full flag
// - Receive-full with enable requests interrupt
// - Status read then data read clears
// - Error flags interrupt only when enabled
// - New byte while full sets overflow
// - Overflow keeps old byte, drops new
// - Status read then data read clears overflow
// - Slave: select rising mid-byte is fault
// - Master: select low sets mode fault
// - Status read then control write clears fault
// - Handoff to shifter sets transmit-empty
// - Data write clears transmit-empty
// - Fault sets only when enabled, stays set
// - Master without fault enable frees select
// - Slave always owns select input
// - Rate select picks divisor 2/8/32/128
// - Serial rate is clock over 2xdivisor
// - Writes go transmit, reads from receive
`timescale 1ns/1ps

module spi_status_flags_and_data
  import spi_flags_pkg::*;
#(
  parameter int unsigned ADDR_W = 4
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  output      logic [7:0]        tx_byte_o,
  output      logic              tx_pending_o,
  input  wire logic              tx_take_i,
  input  wire logic [7:0]        rx_byte_i,
  input  wire logic              rx_done_i,
  input  wire logic              xfer_active_i,
  input  wire logic              ss_n_i,
  output      logic              serial_edge_tick_o,
  output      logic              master_mode_o,
  output      logic              spi_enable_o,
  output      logic              clock_polarity_o,
  output      logic              clock_phase_o,
  output      logic              wired_or_o,
  output      logic              ss_reserved_o,
  output      logic              irq_o
);

  if (ADDR_W < OFS_W) begin : g_addr_w_check
    $error("ADDR_W must cover the register offsets");
  end

  // Divider counter is seven bits; a larger divisor would be cut to seven bits in the compare and wrap early
  if (BAUD_DIV_11 > 8'h80) begin : g_div_check
    $error("Largest divisor exceeds the divider counter");
  end

  // Full address match: offset in low bits, upper bits zero
  function automatic logic reg_hit(input logic [ADDR_W-1:0] adr,
                                   input logic [3:0]        ofs);
    logic upper_zero;
    upper_zero = ((adr >> OFS_W) == '0);
    return upper_zero && (adr[3:0] == ofs);
  endfunction : reg_hit

  function automatic logic [7:0] baud_divisor(input logic [1:0] sel);
    logic [7:0] div;
    div = BAUD_DIV_00;
    case (sel)
      2'b00:   div = BAUD_DIV_00;
      2'b01:   div = BAUD_DIV_01;
      2'b10:   div = BAUD_DIV_10;
      2'b11:   div = BAUD_DIV_11;
      default: div = BAUD_DIV_00;
    endcase
    return div;
  endfunction : baud_divisor

  // Registers and their next values
  ctrl_s       ctrl_q;
  ctrl_s       ctrl_d;
  stat_cfg_s   cfg_q;
  stat_cfg_s   cfg_d;
  flags_s      flags_q;
  flags_s      flags_d;
  logic [7:0]  tx_q;
  logic [7:0]  tx_d;
  logic [7:0]  rx_q;
  logic [7:0]  rx_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic        rx_arm_q;
  logic        rx_arm_d;
  logic        ovr_arm_q;
  logic        ovr_arm_d;
  logic        mf_arm_q;
  logic        mf_arm_d;
  logic        ss_n_q;
  logic [6:0]  div_cnt_q;
  logic [6:0]  div_cnt_d;

  // Bus decode
  wire        wb_req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        wb_done    = wb_cyc_i & wb_stb_i & ack_q;
  wire        hit_ctrl   = reg_hit(wb_adr_i, CTRL_OFS);
  wire        hit_stat   = reg_hit(wb_adr_i, STAT_OFS);
  wire        hit_data   = reg_hit(wb_adr_i, DATA_OFS);
  wire        wr_lane    = wb_done & wb_we_i & wb_sel_i[0];
  wire        rd_done    = wb_done & ~wb_we_i;
  wire        wr_ctrl    = wr_lane & hit_ctrl;
  wire        wr_stat    = wr_lane & hit_stat;
  wire        wr_data    = wr_lane & hit_data;
  wire        rd_stat    = rd_done & hit_stat;
  wire        rd_data    = rd_done & hit_data;

  // Status byte as seen by software
  wire [7:0]  stat_byte  = {flags_q.rx_full_flag,
                            cfg_q.error_irq_enable,
                            flags_q.overflow_flag,
                            flags_q.mode_fault_flag,
                            flags_q.tx_empty_flag,
                            cfg_q.mode_fault_enable,
                            cfg_q.rate_select};

  // Data reads return the receive side only
  // Unmapped offsets answer with zero
  wire [31:0] read_word  = hit_ctrl ? {24'h000000, ctrl_q}    :
                           hit_stat ? {24'h000000, stat_byte} :
                           hit_data ? {24'h000000, rx_q}      :
                           32'h00000000;

  // Mode qualifiers
  wire        slave_act  = ctrl_q.spi_enable & ~ctrl_q.master_select;
  wire        master_act = ctrl_q.spi_enable & ctrl_q.master_select;

  // Receive path
  wire        rx_clear   = rd_data & rx_arm_q;
  wire        ovr_clear  = rd_data & ovr_arm_q;
  // A read that empties the register in the arrival cycle lets the byte in
  wire        rx_load    = rx_done_i & (~flags_q.rx_full_flag | rx_clear);
  wire        ovr_set    = rx_done_i & flags_q.rx_full_flag & ~rx_clear;

  // Mode fault detection
  wire        ss_rise    = ss_n_i & ~ss_n_q;
  wire        mf_slave   = slave_act & xfer_active_i & ss_rise;
  wire        mf_master  = master_act & ~ss_n_i;
  wire        mf_set     = cfg_q.mode_fault_enable & (mf_slave | mf_master);
  wire        mf_clear   = wr_ctrl & mf_arm_q;

  // Baud divider, counts only in an enabled master
  wire [7:0]  div_val    = baud_divisor(cfg_q.rate_select);
  wire [7:0]  div_m1     = div_val - 8'h01;
  // At or above, so a smaller divisor written mid-count wraps at once
  wire        div_wrap   = (div_cnt_q >= div_m1[6:0]);
  wire        edge_tick  = master_act & div_wrap;

  // Interrupt sources
  // Level requests: each stays up until its flag is cleared
  wire        rx_irq     = flags_q.rx_full_flag & ctrl_q.rx_full_irq_enable;
  wire        tx_irq     = flags_q.tx_empty_flag & ctrl_q.tx_empty_irq_enable;
  wire        err_irq    = cfg_q.error_irq_enable &
                           (flags_q.overflow_flag | flags_q.mode_fault_flag);

  // Bus answer: one wait state on every address, mapped or not
  always_comb begin
    ack_d = wb_req;
    dat_d = wb_req ? read_word : dat_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d           = ctrl_s'(wb_dat_i[7:0]);
      // Reserved bit reads zero whatever is written
      ctrl_d.reserved6 = 1'b0;
    end
  end

  // Flags are read-only: a status write only reaches the setup bits
  always_comb begin
    cfg_d = cfg_q;
    if (wr_stat) begin
      cfg_d.error_irq_enable  = wb_dat_i[ERR_IE_POS];
      cfg_d.mode_fault_enable = wb_dat_i[MF_ENABLE_POS];
      cfg_d.rate_select       = {wb_dat_i[RATE_HI_POS], wb_dat_i[RATE_LO_POS]};
    end
  end

  // Receive byte held while full; the late byte is dropped
  assign rx_d = rx_load ? rx_byte_i : rx_q;

  // Transmit register is write-only and never read back
  assign tx_d = wr_data ? wb_dat_i[7:0] : tx_q;

  // Sets win over clears on every flag, so no event is lost
  always_comb begin
    flags_d                 = flags_q;
    flags_d.rx_full_flag    = rx_load | (flags_q.rx_full_flag & ~rx_clear);
    flags_d.overflow_flag   = ovr_set | (flags_q.overflow_flag & ~ovr_clear);
    flags_d.mode_fault_flag = mf_set | (flags_q.mode_fault_flag & ~mf_clear);
    flags_d.tx_empty_flag   = tx_take_i | (flags_q.tx_empty_flag & ~wr_data);
  end

  // Arms record a status read that returned the flag set; the returned
  // byte is used, so a flag that rises during the access cannot arm
  always_comb begin
    rx_arm_d = rx_arm_q;
    if (rd_stat && dat_q[RX_FULL_POS]) begin
      rx_arm_d = 1'b1;
    end else if (rd_data) begin
      rx_arm_d = 1'b0;
    end
  end

  always_comb begin
    ovr_arm_d = ovr_arm_q;
    if (rd_stat && dat_q[OVERFLOW_POS]) begin
      ovr_arm_d = 1'b1;
    end else if (rd_data) begin
      ovr_arm_d = 1'b0;
    end
  end

  // Only a control write disarms the mode fault clear
  always_comb begin
    mf_arm_d = mf_arm_q;
    if (rd_stat && dat_q[MODE_FAULT_POS]) begin
      mf_arm_d = 1'b1;
    end else if (wr_ctrl) begin
      mf_arm_d = 1'b0;
    end
  end

  // Counter restarts whenever the block is not an enabled master
  always_comb begin
    div_cnt_d = div_cnt_q + 7'h01;
    if (!master_act || div_wrap) begin
      div_cnt_d = 7'h00;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dat_q <= 32'h00000000;
    end else begin
      dat_q <= dat_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= ctrl_s'(CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_q <= stat_cfg_s'(STAT_CFG_RST);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Transmit-empty leaves reset set: nothing waits to be sent
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flags_q <= flags_s'(FLAGS_RST);
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tx_q <= DATA_RST;
    end else begin
      tx_q <= tx_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_q <= DATA_RST;
    end else begin
      rx_q <= rx_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_arm_q <= 1'b0;
    end else begin
      rx_arm_q <= rx_arm_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ovr_arm_q <= 1'b0;
    end else begin
      ovr_arm_q <= ovr_arm_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mf_arm_q <= 1'b0;
    end else begin
      mf_arm_q <= mf_arm_d;
    end
  end

  // Idle level after reset, so no false rise follows reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ss_n_q <= 1'b1;
    end else begin
      ss_n_q <= ss_n_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= 7'h00;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // Bus answer comes straight from flip-flops
  assign wb_ack_o           = ack_q;
  assign wb_dat_o           = dat_q;
  assign tx_byte_o          = tx_q;
  // Engine may only take while a byte waits; software keeps to empty-only writes
  assign tx_pending_o       = ~flags_q.tx_empty_flag;
  assign serial_edge_tick_o = edge_tick;
  // Control bits go straight to the shift engine
  assign master_mode_o      = ctrl_q.master_select;
  assign spi_enable_o       = ctrl_q.spi_enable;
  assign clock_polarity_o   = ctrl_q.clock_polarity;
  assign clock_phase_o      = ctrl_q.clock_phase;
  assign wired_or_o         = ctrl_q.wired_or;
  // Slave always owns the pin; master only with fault detection
  assign ss_reserved_o      = slave_act | (master_act & cfg_q.mode_fault_enable);
  assign irq_o              = rx_irq | tx_irq | err_irq;

endmodule : spi_status_flags_and_data

// File: testbench/spi_flags_chk.sv
/*
  Port checker for the serial flag block: bus handshake, transmit path,
  divider ticks and slave-select ownership.
  Assumes a single clock domain and the package's register offsets.
*/
`timescale 1ns/1ps
module spi_flags_chk
  import spi_flags_pkg::*;
#(
  parameter int unsigned ADDR_W = 4
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic [7:0]        tx_byte_o,
  input wire logic              tx_pending_o,
  input wire logic              tx_take_i,
  input wire logic              serial_edge_tick_o,
  input wire logic              master_mode_o,
  input wire logic              spi_enable_o,
  input wire logic              ss_reserved_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic dwr;
  logic unm;
  assign dwr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == DATA_OFS;
  assign unm = !(wb_adr_i inside {CTRL_OFS, STAT_OFS, DATA_OFS});
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_unmap; wb_ack_o && !wb_we_i && unm |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_tx_data; dwr |=> tx_byte_o == $past(wb_dat_i[7:0]); endproperty
  a_tx_data: assert property (p_tx_data) else $error("tx byte");
  property p_tx_clr; dwr && !tx_take_i |=> tx_pending_o; endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx not pending");
  property p_tx_set; tx_take_i |=> !tx_pending_o; endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx not empty");
  property p_tick_mode; serial_edge_tick_o |-> master_mode_o && spi_enable_o; endproperty
  a_tick_mode: assert property (p_tick_mode) else $error("tick in slave");
  property p_tick_gap; serial_edge_tick_o |=> !serial_edge_tick_o; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick gap");
  property p_ss_slave; spi_enable_o && !master_mode_o |-> ss_reserved_o; endproperty
  a_ss_slave: assert property (p_ss_slave) else $error("slave select freed");
  property p_ss_off; !spi_enable_o |-> !ss_reserved_o; endproperty
  a_ss_off: assert property (p_ss_off) else $error("select held off");
  c_dwr: cover property (dwr);
  c_tick: cover property (serial_edge_tick_o);
  c_take: cover property (tx_take_i);
endmodule : spi_flags_chk

bind spi_status_flags_and_data spi_flags_chk #(.ADDR_W(ADDR_W)) i_chk (
  .clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_byte_o, .tx_pending_o, .tx_take_i,
  .serial_edge_tick_o, .master_mode_o, .spi_enable_o, .ss_reserved_o
);

// File: testbench/shift_peer.sv
/*
  Behavioural shift engine facing the flag block.
  Assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/1ps
module shift_peer (
  input  wire logic       clk_i,
  input  wire logic       pending_i,
  input  wire logic [7:0] tx_i,
  output      logic       take_o,
  output      logic [7:0] rx_o,
  output      logic       done_o,
  output      logic       active_o
);
  logic [7:0] sent_q = 8'h00;
  initial begin
    take_o = 1'b0;
    rx_o = 8'h5a;
    done_o = 1'b0;
    active_o = 1'b0;
  end
  // Stall g cycles mid-byte to look like a slow link
  task automatic xfer(input logic [7:0] v, input int g);
    @(posedge clk_i);
    active_o <= 1'b1;
    take_o <= pending_i;
    if (pending_i) sent_q <= tx_i;
    @(posedge clk_i);
    take_o <= 1'b0;
    repeat (g) @(posedge clk_i);
    rx_o <= v;
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    active_o <= 1'b0;
    rx_o <= ~v; // Stale data never repeats
  endtask : xfer
endmodule : shift_peer

// File: testbench/testbench.sv
/*
  Self-checking bench for the serial flag block with a reference model.
  Assumes the checker is bound and the peer stands in for the shift engine.
*/
`timescale 1ns/1ps
module testbench;
  import spi_flags_pkg::*;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        ss_n = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h00000000, wb_dat_o, seed = 32'h2016f91d;
  logic [7:0]  tx_byte_o, rx_b, m_ctl = 8'h28, m_cfg = 0, m_rx = 0, m_tx = 0;
  logic        wb_ack_o, tx_pending_o, tk, rd, act, serial_edge_tick_o;
  logic        master_mode_o, spi_enable_o, ss_reserved_o, irq_o;
  logic        clock_polarity_o, clock_phase_o, wired_or_o;
  logic [3:0]  ofs [4] = '{CTRL_OFS, STAT_OFS, DATA_OFS, 4'hc};
  bit          rf, ov, mf, te = 1, arx, aov, amf;
  int          err_count = 0, n_tests = 0, n;
  always #50 clk_sys_i = ~clk_sys_i;
  spi_status_flags_and_data i_spi_status_flags_and_data (.clk_sys_i, .rst_n_i,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .tx_byte_o, .tx_pending_o, .tx_take_i(tk),
    .rx_byte_i(rx_b), .rx_done_i(rd), .xfer_active_i(act), .ss_n_i(ss_n),
    .serial_edge_tick_o, .master_mode_o, .spi_enable_o, .clock_polarity_o,
    .clock_phase_o, .wired_or_o, .ss_reserved_o, .irq_o);
  shift_peer i_shift_peer (.clk_i(clk_sys_i), .pending_i(tx_pending_o), .tx_i(tx_byte_o),
    .take_o(tk), .rx_o(rx_b), .done_o(rd), .active_o(act));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task end_sim();
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task acc(input bit w, input logic [3:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = (a == CTRL_OFS) ? m_ctl : (a == DATA_OFS) ? m_rx : (a == STAT_OFS) ?
        {rf, m_cfg[6], ov, mf, te, m_cfg[2:0]} : 8'h00;
    @(posedge clk_sys_i);
    chk({6'h0, irq_o, tx_pending_o}, {6'h0, (rf & m_ctl[7]) | (te & m_ctl[1]) |
        (m_cfg[6] & (ov | mf)), !te});
    chk(tx_byte_o, m_tx);
    chk({2'h0, ss_reserved_o, master_mode_o, clock_polarity_o, clock_phase_o,
        wired_or_o, spi_enable_o}, {2'h0, m_ctl[0] & (!m_ctl[5] | m_cfg[2]),
        m_ctl[5:2], m_ctl[0]});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (!w) chk(wb_dat_o[7:0], e);
    if (!w && a == STAT_OFS) {arx, aov, amf} = {rf, ov, mf};
    if (!w && a == DATA_OFS) begin
      rf &= !arx; ov &= !aov; arx = 0; aov = 0;
    end
    if (w && a == CTRL_OFS) begin
      m_ctl = d & 8'hbf; mf &= !amf; amf = 0;
    end
    if (w && a == STAT_OFS) m_cfg = d & 8'h47;
    if (w && a == DATA_OFS) begin
      te = 0; m_tx = d;
    end
  endtask : acc
  task rx(input logic [7:0] v, input int g);
    bit pend;
    pend = !te;
    i_shift_peer.xfer(v, g);
    if (pend) chk(i_shift_peer.sent_q, m_tx);
    te = 1;
    if (rf) ov = 1;
    else begin m_rx = v; rf = 1; end
  endtask : rx
  task pulse();
    @(posedge clk_sys_i) ss_n <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    ss_n <= 1'b1;
  endtask : pulse
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (ofs[i]) acc(0, ofs[i], 8'h00);
    acc(1, CTRL_OFS, 8'hff);
    acc(1, STAT_OFS, 8'h40);
    for (int i = 0; i < 4; i++) begin
      if (te) acc(1, DATA_OFS, 8'(xs()));
      rx(8'(xs()), i);
      acc(0, STAT_OFS, 8'h00);
    end
    acc(0, DATA_OFS, 8'h00);
    acc(0, STAT_OFS, 8'h00);
    acc(0, DATA_OFS, 8'h00);
    acc(1, STAT_OFS, 8'h44);
    pulse(); mf = 1;
    acc(1, STAT_OFS, 8'h40);
    acc(0, STAT_OFS, 8'h00);
    acc(1, CTRL_OFS, 8'hff);
    pulse();
    acc(0, STAT_OFS, 8'h00);
    acc(1, CTRL_OFS, 8'h01);
    acc(1, STAT_OFS, 8'h44);
    ss_n <= 0;
    fork
      rx(8'(xs()), 4);
      begin repeat (2) @(posedge clk_sys_i); ss_n <= 1; mf = 1; end
    join
    acc(0, STAT_OFS, 8'h00);
    acc(0, DATA_OFS, 8'h00);
    acc(1, CTRL_OFS, 8'h21);
    for (int r = 0; r < 4; r++) begin
      acc(1, STAT_OFS, 8'(r));
      repeat (2) do @(posedge clk_sys_i); while (serial_edge_tick_o !== 1'b1);
      n = 0;
      do begin @(posedge clk_sys_i); n++; end while (serial_edge_tick_o !== 1'b1);
      chk(8'(n), 8'(2 << (2 * r)));
    end
    end_sim();
  end
endmodule : testbench
